// ### rtl/ams_pkg.sv
// Purpose: Constants and types for the converter mode sequencer
// Assumes: 32-bit AXI4-Lite register bus, one 100 MHz clock
// Notes: Register offsets are byte addresses on the local bus
package ams_pkg;
  localparam int unsigned RES_W = 24;
  localparam int unsigned NCONV = 2;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RES0 = 8'h0C;
  localparam logic [7:0] OFS_RES1 = 8'h10;
  localparam logic [7:0] OFS_GAIN0 = 8'h14;
  localparam logic [7:0] OFS_GAIN1 = 8'h18;
  // Mode register fields
  localparam int unsigned OPM_LO = 0;
  localparam int unsigned OPM_HI = 2;
  localparam int unsigned PCFG_LO = 3;
  localparam int unsigned PCFG_HI = 4;
  localparam logic [7:0] MODE_RST = 8'h03;
  localparam logic [7:0] MODE_MASK = 8'hBF;
  // Config register fields
  localparam int unsigned CFG_EN_LO = 0;
  localparam int unsigned CFG_CHOP = 2;
  localparam logic [2:0] CFG_RST = 3'h0;
  // Status register fields
  localparam int unsigned STA_CAL = 2;
  // Arbitrary neutral gain reset value
  localparam logic [RES_W-1:0] GAIN_RST = 24'h400000;
  // Conversion length in converter ticks
  localparam logic [2:0] TICKS_PLAIN = 3'h2;
  localparam logic [2:0] TICKS_CHOP = 3'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_PDOWN = 3'b000,
    OP_CONT = 3'b001,
    OP_SINGLE = 3'b010,
    OP_IDLE = 3'b011,
    OP_OFFCAL = 3'b100,
    OP_GAINCAL = 3'b101
  } ams_op_t;

  typedef enum logic [1:0] {
    PC_NORMAL = 2'b00,
    PC_LOWP = 2'b01,
    PC_NORMAL_ALT = 2'b10,
    PC_LOWP_PLUS = 2'b11
  } ams_pcfg_t;

  typedef struct packed {
    logic power_down;
    logic low_power;
    logic pga_off;
    logic conv_reset;
    logic zero_input;
    logic ref_input;
    logic prim_on;
    logic aux_on;
  } ams_pwr_t;
endpackage

// ### rtl/ams_mode_seq.sv
// Purpose: Mode register, conversion and calibration sequencer
// Assumes: conv_tick and results come from logic on clk
// Notes: Registers reached over AXI4-Lite, one word each
`timescale 1ns/1ps
`default_nettype none
module ams_mode_seq
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic conv_tick,
  input wire logic [ams_pkg::RES_W-1:0] prim_result,
  input wire logic [ams_pkg::RES_W-1:0] aux_result,
  output ams_pkg::ams_pwr_t pwr_ctl,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    logic [7:0] mode;
    logic [ams_pkg::NCONV-1:0] en;
    logic chop;
    logic [2:0] cnt;
    logic [ams_pkg::NCONV-1:0] rdy;
    logic cal_done;
    logic [ams_pkg::NCONV-1:0][ams_pkg::RES_W-1:0] res;
    logic [ams_pkg::NCONV-1:0][ams_pkg::RES_W-1:0] gain;
    ams_pkg::ams_pwr_t pwr;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ams_state_t;

  ams_state_t s;
  ams_state_t next_s;
  logic wr_take;
  logic rd_take;
  logic mode_wr;
  logic seq_active;
  logic seq_done;
  logic [2:0] conv_len;
  logic [2:0] total_len;
  logic [ams_pkg::NCONV-1:0][ams_pkg::RES_W-1:0] conv_in;
  ams_pkg::ams_op_t op;
  logic [31:0] mode_merge;
  logic [31:0] gain0_merge;
  logic [31:0] gain1_merge;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge_strb(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Outputs of the power decode for one mode value
  function automatic ams_pkg::ams_pwr_t decode_pwr(
    input logic [7:0] m,
    input logic [ams_pkg::NCONV-1:0] en
  );
    ams_pkg::ams_pwr_t p;
    logic [2:0] o;
    logic [1:0] pc;
    o = m[ams_pkg::OPM_HI:ams_pkg::OPM_LO];
    pc = m[ams_pkg::PCFG_HI:ams_pkg::PCFG_LO];
    p = '0;
    p.power_down = (o == ams_pkg::OP_PDOWN);
    // Codes 00 and 10 both decode as normal current
    p.low_power = pc[0];
    p.pga_off = (pc == ams_pkg::PC_LOWP_PLUS) || p.power_down;
    p.conv_reset = (o == ams_pkg::OP_IDLE);
    p.zero_input = (o == ams_pkg::OP_OFFCAL);
    p.ref_input = (o == ams_pkg::OP_GAINCAL);
    p.prim_on = en[0] && !p.power_down;
    p.aux_on = en[1] && !p.power_down;
    return p;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Bus handshakes, frozen while the clock enable is low
  assign wr_take = ce && s_axi_awvalid && s_axi_wvalid && !s.bvalid;
  assign rd_take = ce && s_axi_arvalid && !s.rvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = rd_take;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign pwr_ctl = s.pwr;

  assign mode_wr = wr_take && (s_axi_awaddr == ams_pkg::OFS_MODE);
  assign op = ams_pkg::ams_op_t'(s.mode[ams_pkg::OPM_HI:ams_pkg::OPM_LO]);
  assign conv_in[0] = prim_result;
  assign conv_in[1] = aux_result;
  // Write data merged per byte lane into the mode word and both gain words
  assign mode_merge = merge_strb({24'h0, s.mode}, s_axi_wdata, s_axi_wstrb);
  assign gain0_merge = merge_strb({8'h0, s.gain[0]}, s_axi_wdata,
    s_axi_wstrb);
  assign gain1_merge = merge_strb({8'h0, s.gain[1]}, s_axi_wdata,
    s_axi_wstrb);

  // Codes 110 and 111 run nothing
  assign seq_active = (op == ams_pkg::OP_CONT) || (op == ams_pkg::OP_SINGLE)
    || (op == ams_pkg::OP_OFFCAL) || (op == ams_pkg::OP_GAINCAL);
  assign conv_len = s.chop ? ams_pkg::TICKS_CHOP : ams_pkg::TICKS_PLAIN;
  // Offset cal uses the same length, gain cal twice it
  assign total_len = (op == ams_pkg::OP_GAINCAL) ? 3'(conv_len << 1)
    : conv_len;
  // A mode write restarts the sequence instead of finishing it
  assign seq_done = ce && seq_active && conv_tick && !mode_wr
    && (3'(s.cnt + 3'h1) == total_len);

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s = s;
    if (ce)
    begin
      if (s.bvalid && s_axi_bready)
      begin
        next_s.bvalid = 1'b0;
      end
      if (s.rvalid && s_axi_rready)
      begin
        next_s.rvalid = 1'b0;
      end
      // Register writes; clears come before hardware sets below
      if (wr_take)
      begin
        next_s.bvalid = 1'b1;
        next_s.bresp = ams_pkg::RESP_OKAY;
        case (s_axi_awaddr)
          ams_pkg::OFS_MODE:
          begin
            next_s.mode = mode_merge[7:0] & ams_pkg::MODE_MASK;
            next_s.cnt = 3'h0;
          end
          ams_pkg::OFS_CFG:
          begin
            if (s_axi_wstrb[0])
            begin
              next_s.en = s_axi_wdata[ams_pkg::CFG_EN_LO +: ams_pkg::NCONV];
              next_s.chop = s_axi_wdata[ams_pkg::CFG_CHOP];
            end
          end
          ams_pkg::OFS_STATUS:
          begin
            if (s_axi_wstrb[0] && s_axi_wdata[ams_pkg::STA_CAL])
            begin
              next_s.cal_done = 1'b0;
            end
          end
          ams_pkg::OFS_GAIN0:
          begin
            next_s.gain[0] = gain0_merge[ams_pkg::RES_W-1:0];
          end
          ams_pkg::OFS_GAIN1:
          begin
            next_s.gain[1] = gain1_merge[ams_pkg::RES_W-1:0];
          end
          default:
          begin
            next_s.bresp = ams_pkg::RESP_SLVERR;
          end
        endcase
      end
      // Register reads; result reads clear that converter's ready
      if (rd_take)
      begin
        next_s.rvalid = 1'b1;
        next_s.rresp = ams_pkg::RESP_OKAY;
        case (s_axi_araddr)
          ams_pkg::OFS_MODE: next_s.rdata = {24'h0, s.mode};
          ams_pkg::OFS_CFG: next_s.rdata = {29'h0, s.chop, s.en};
          ams_pkg::OFS_STATUS: next_s.rdata = {29'h0, s.cal_done, s.rdy};
          ams_pkg::OFS_RES0:
          begin
            next_s.rdata = {8'h0, s.res[0]};
            next_s.rdy[0] = 1'b0;
          end
          ams_pkg::OFS_RES1:
          begin
            next_s.rdata = {8'h0, s.res[1]};
            next_s.rdy[1] = 1'b0;
          end
          ams_pkg::OFS_GAIN0: next_s.rdata = {8'h0, s.gain[0]};
          ams_pkg::OFS_GAIN1: next_s.rdata = {8'h0, s.gain[1]};
          default:
          begin
            next_s.rdata = 32'h0;
            next_s.rresp = ams_pkg::RESP_SLVERR;
          end
        endcase
      end
      // Sequencer: counts converter ticks of the running conversion
      if (seq_active && conv_tick && !mode_wr)
      begin
        next_s.cnt = seq_done ? 3'h0 : 3'(s.cnt + 3'h1);
      end
      if (seq_done)
      begin
        case (op)
          ams_pkg::OP_CONT:
          begin
            // Full converters drop the sample; no overwrite of unread data
            for (int i = 0; i < ams_pkg::NCONV; i++)
            begin
              if (s.en[i] && !s.rdy[i])
              begin
                next_s.res[i] = conv_in[i];
                next_s.rdy[i] = 1'b1;
              end
            end
          end
          ams_pkg::OP_SINGLE:
          begin
            for (int i = 0; i < ams_pkg::NCONV; i++)
            begin
              if (s.en[i])
              begin
                next_s.res[i] = conv_in[i];
                next_s.rdy[i] = 1'b1;
              end
            end
            next_s.mode[ams_pkg::OPM_HI:ams_pkg::OPM_LO] = ams_pkg::OP_IDLE;
          end
          ams_pkg::OP_OFFCAL:
          begin
            next_s.rdy = s.rdy | s.en;
            next_s.cal_done = 1'b1;
            next_s.mode[ams_pkg::OPM_HI:ams_pkg::OPM_LO] = ams_pkg::OP_IDLE;
          end
          ams_pkg::OP_GAINCAL:
          begin
            for (int i = 0; i < ams_pkg::NCONV; i++)
            begin
              if (s.en[i])
              begin
                next_s.gain[i] = conv_in[i];
              end
            end
            next_s.rdy = s.rdy | s.en;
            next_s.cal_done = 1'b1;
            next_s.mode[ams_pkg::OPM_HI:ams_pkg::OPM_LO] = ams_pkg::OP_IDLE;
          end
          default:
          begin
            next_s.cnt = 3'h0;
          end
        endcase
      end
      next_s.pwr = decode_pwr(next_s.mode, next_s.en);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.mode <= ams_pkg::MODE_RST;
      s.en <= ams_pkg::CFG_RST[1:0];
      s.chop <= ams_pkg::CFG_RST[ams_pkg::CFG_CHOP];
      s.gain <= {ams_pkg::NCONV{ams_pkg::GAIN_RST}};
      s.pwr.conv_reset <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_single_to_idle: assert property (
    seq_done && op == ams_pkg::OP_SINGLE
    |=> s.mode[ams_pkg::OPM_HI:ams_pkg::OPM_LO] == ams_pkg::OP_IDLE
      && s.pwr.conv_reset)
    else $error("single conversion did not return to idle");

  a_cont_no_overwrite: assert property (
    seq_done && op == ams_pkg::OP_CONT && s.rdy[0]
    |=> s.res[0] == $past(s.res[0]))
    else $error("continuous result overwrote unread data");

  a_offcal_flags: assert property (
    seq_done && op == ams_pkg::OP_OFFCAL
    |=> s.cal_done && ((s.rdy & s.en) == s.en)
      && s.mode[ams_pkg::OPM_HI:ams_pkg::OPM_LO] == ams_pkg::OP_IDLE)
    else $error("offset calibration end flags wrong");

  a_gain_write: assert property (
    seq_done && op == ams_pkg::OP_GAINCAL && s.en[0]
    |=> s.gain[0] == $past(prim_result))
    else $error("gain calibration result not stored");

  a_gain_length: assert property (
    seq_done && op == ams_pkg::OP_GAINCAL
    |-> s.cnt == 3'((s.chop ? ams_pkg::TICKS_CHOP : ams_pkg::TICKS_PLAIN)
      * 2 - 1))
    else $error("gain calibration length wrong");

  a_pdown_power: assert property (
    ce && s_axi_wvalid && mode_wr && s_axi_wstrb[0]
      && s_axi_wdata[ams_pkg::OPM_HI:ams_pkg::OPM_LO] == ams_pkg::OP_PDOWN
    |=> s.pwr.power_down && s.pwr.pga_off && !s.pwr.prim_on)
    else $error("power-down did not switch circuits off");

  a_lpplus_pga: assert property (
    s.mode[ams_pkg::PCFG_HI:ams_pkg::PCFG_LO] == ams_pkg::PC_LOWP_PLUS
      && $stable(s.mode)
    |-> s.pwr.low_power && s.pwr.pga_off)
    else $error("low power plus lacks amplifier off");

  a_normal_cfg: assert property (
    !s.mode[ams_pkg::PCFG_LO] && $stable(s.mode)
      && s.mode[ams_pkg::OPM_HI:ams_pkg::OPM_LO] != ams_pkg::OP_PDOWN
    |-> !s.pwr.low_power && !s.pwr.pga_off)
    else $error("normal configuration not at full current");

  a_rdy_read_clear: assert property (
    rd_take && s_axi_araddr == ams_pkg::OFS_RES0 && !seq_done
    |=> !s.rdy[0])
    else $error("primary ready not cleared by result read");

endmodule // ams_mode_seq
`default_nettype wire

// ### verif/test_adc_mode_sequencer.sv
// Purpose: Self-checking bench for the converter mode sequencer
// Assumes: ce high except in the clock enable test; converter ticks driven by the bench
// Notes: Registers reached through AXI4-Lite tasks only
`timescale 1ns/1ps
`default_nettype none
module test_adc_mode_sequencer;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic conv_tick = 1'b0;
  logic [23:0] prim_result = 24'hA5A5A5;
  logic [23:0] aux_result = 24'h5A5A5A;
  ams_pkg::ams_pwr_t pwr_ctl;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] rdat;
  logic [1:0] rrsp;
  logic [1:0] brsp;
  int errors = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  ams_mode_seq uut (.clk(clk), .rst_b(rst_b), .ce(ce), .conv_tick(conv_tick),
    .prim_result(prim_result), .aux_result(aux_result), .pwr_ctl(pwr_ctl),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (!bvalid);
    brsp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rdat = rdata;
    rrsp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // n converter ticks, each followed by two cycles of settling room for the flags
  task automatic tick(input int n);
    repeat (n)
    begin
      conv_tick <= 1'b1;
      @(posedge clk);
      conv_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(ams_pkg::OFS_MODE);
    chk("mode reset", rdat, 32'h03);
    chk("conv_reset", 32'(pwr_ctl.conv_reset), 32'h1);
    rd(ams_pkg::OFS_GAIN0);
    chk("gain0 reset", rdat, 32'h400000);
    rd(8'h40);
    chk("unmapped resp", 32'(rrsp), 32'(ams_pkg::RESP_SLVERR));
    wr(8'h40, 32'h0);
    chk("unmapped wresp", 32'(brsp), 32'(ams_pkg::RESP_SLVERR));
    $display("test reset done");
    // Every power configuration, idle operation
    for (int p = 0; p < 4; p++)
    begin
      // Low power codes also set the low power enable bit
      wr(ams_pkg::OFS_MODE, 32'(p * 8 + 3 + (p % 2) * 32));
      chk("mode bresp", 32'(brsp), 32'(ams_pkg::RESP_OKAY));
      rd(ams_pkg::OFS_MODE);
      chk("pcfg", rdat, 32'(p * 8 + 3 + (p % 2) * 32));
      chk("low_power", 32'(pwr_ctl.low_power), 32'(p % 2));
      chk("pga_off", 32'(pwr_ctl.pga_off), 32'(p == 3));
      chk("idle reset", 32'(pwr_ctl.conv_reset), 32'h1);
    end
    wr(ams_pkg::OFS_MODE, 32'h00);
    chk("power_down", 32'(pwr_ctl.power_down), 32'h1);
    chk("pd pga_off", 32'(pwr_ctl.pga_off), 32'h1);
    $display("test power done");
    // Single conversion, primary only, no chopping
    wr(ams_pkg::OFS_CFG, 32'h01);
    wr(ams_pkg::OFS_MODE, 32'h02);
    tick(1);
    rd(ams_pkg::OFS_MODE);
    chk("single mid", rdat, 32'h02);
    chk("prim_on", 32'(pwr_ctl.prim_on), 32'h1);
    chk("aux_off", 32'(pwr_ctl.aux_on), 32'h0);
    tick(1);
    rd(ams_pkg::OFS_MODE);
    chk("single end", rdat, 32'h03);
    rd(ams_pkg::OFS_STATUS);
    chk("single rdy", rdat & 32'h7, 32'h1);
    rd(ams_pkg::OFS_RES0);
    chk("single res", rdat, 32'hA5A5A5);
    rd(ams_pkg::OFS_STATUS);
    chk("rdy cleared", rdat & 32'h7, 32'h0);
    $display("test single done");
    // Continuous, both converters; held-off result while ready set
    wr(ams_pkg::OFS_CFG, 32'h03);
    wr(ams_pkg::OFS_MODE, 32'h01);
    tick(2);
    rd(ams_pkg::OFS_STATUS);
    chk("cont rdy", rdat & 32'h3, 32'h3);
    chk("aux_on", 32'(pwr_ctl.aux_on), 32'h1);
    prim_result <= 24'h123456;
    tick(2);
    rd(ams_pkg::OFS_RES0);
    chk("cont held", rdat, 32'hA5A5A5);
    tick(2);
    rd(ams_pkg::OFS_RES0);
    chk("cont new", rdat, 32'h123456);
    rd(ams_pkg::OFS_MODE);
    chk("cont stays", rdat, 32'h01);
    wr(ams_pkg::OFS_MODE, 32'h03);
    rd(ams_pkg::OFS_RES0);
    rd(ams_pkg::OFS_RES1);
    chk("aux res", rdat, 32'h5A5A5A);
    $display("test continuous done");
    // Offset calibration with chopping: three ticks
    wr(ams_pkg::OFS_CFG, 32'h05);
    wr(ams_pkg::OFS_MODE, 32'h04);
    tick(2);
    rd(ams_pkg::OFS_MODE);
    chk("ocal mid", rdat, 32'h04);
    chk("zero_input", 32'(pwr_ctl.zero_input), 32'h1);
    tick(1);
    rd(ams_pkg::OFS_MODE);
    chk("ocal idle", rdat, 32'h03);
    rd(ams_pkg::OFS_STATUS);
    chk("ocal flags", rdat & 32'h7, 32'h5);
    wr(ams_pkg::OFS_STATUS, 32'h4);
    rd(ams_pkg::OFS_RES0);
    rd(ams_pkg::OFS_STATUS);
    chk("flags clear", rdat & 32'h7, 32'h0);
    $display("test offset cal done");
    // Gain calibration: twice the plain length
    wr(ams_pkg::OFS_CFG, 32'h01);
    prim_result <= 24'h3C3C3C;
    wr(ams_pkg::OFS_MODE, 32'h05);
    tick(3);
    rd(ams_pkg::OFS_MODE);
    chk("gcal mid", rdat, 32'h05);
    chk("ref_input", 32'(pwr_ctl.ref_input), 32'h1);
    tick(1);
    rd(ams_pkg::OFS_MODE);
    chk("gcal idle", rdat, 32'h03);
    rd(ams_pkg::OFS_STATUS);
    chk("gcal flags", rdat & 32'h7, 32'h5);
    rd(ams_pkg::OFS_GAIN0);
    chk("gain0", rdat, 32'h3C3C3C);
    rd(ams_pkg::OFS_GAIN1);
    chk("gain1", rdat, 32'h400000);
    $display("test gain cal done");
    // Clock enable low freezes a running single conversion
    wr(ams_pkg::OFS_MODE, 32'h02);
    ce <= 1'b0;
    tick(2);
    ce <= 1'b1;
    rd(ams_pkg::OFS_MODE);
    chk("ce frozen", rdat, 32'h02);
    tick(2);
    rd(ams_pkg::OFS_MODE);
    chk("ce resumed", rdat, 32'h03);
    $display("test clock enable done");
    // Reserved code runs nothing
    wr(ams_pkg::OFS_MODE, 32'h06);
    tick(4);
    rd(ams_pkg::OFS_MODE);
    chk("reserved", rdat, 32'h06);
    chk("res no rst", 32'(pwr_ctl.conv_reset), 32'h0);
    chk("res no pd", 32'(pwr_ctl.power_down), 32'h0);
    wr(ams_pkg::OFS_CFG, 32'h03);
    wr(ams_pkg::OFS_MODE, 32'h00);
    chk("pd prim off", 32'(pwr_ctl.prim_on), 32'h0);
    chk("pd aux off", 32'(pwr_ctl.aux_on), 32'h0);
    $display("test reserved done");
    report_and_stop();
  end
endmodule // test_adc_mode_sequencer
`default_nettype wire
